// >>> host_reader.sv
// Upstream host model that fetches maker string characters.
// Assumes the hub core character port of hub_descriptor_config.
`timescale 1ns/1ps
module host_reader
(
   // Clock
   input wire logic                   pclk,
   // Hub core
   input wire logic                   strings_offered,
   input wire hub_cfg_pkg::str_rsp_t  maker_rsp,
   output     hub_cfg_pkg::str_req_t  maker_req
);
   initial maker_req = '0;
   // A released index shows its inverse so a stale address cannot match.
   task fetch(input logic [5:0] idx, output logic ok, output logic [15:0] chr);
      chr = 16'h0000;
      ok = strings_offered;
      if (ok)
      begin
         @(posedge pclk);
         maker_req <= '{req: 1'b1, addr: idx};
         @(posedge pclk);
         maker_req <= '{req: 1'b0, addr: ~idx};
         #1;
         ok = maker_rsp.valid;
         chr = maker_rsp.chr;
      end
   endtask : fetch
endmodule : host_reader

// >>> hub_cfg_pkg.sv
// Constants, field layouts and carrier types for the hub descriptor configuration bank.
// Assumes an APB master on pclk and a descriptor engine in the hub core reading the outputs.
// What this block does
// - Self-powered maximum power register holds eight bits in 2 mA units.
// - Bus-powered maximum power register holds eight bits, default 50 meaning 100 mA.
// - Maximum power values include a zero-reporting embedded compound peripheral.
// - Self-powered controller current holds eight bits, excluding embedded peripheral.
// - Bus-powered controller current holds eight bits, default 50, excluding peripheral.
// - Port power settle time in 2 ms units from power-on start to stable.
// - Language identifier is high register in bits 15:8, low register in 7:0.
// - Maker string length in characters; a value above 31 is flagged in status, not clipped.
// - String descriptors are offered only while the string enable bit is one.
// - String characters are UTF-16LE, low byte at lower address, 62 bytes at most.
package hub_cfg_pkg;

   // ==========================================================================
   // Register indices; the byte address is four times the index, and an address that
   // is not a multiple of four is refused.
   localparam logic [7:0] IDX_SP_MAX_PWR  = 8'h0C;
   localparam logic [7:0] IDX_BP_MAX_PWR  = 8'h0D;
   localparam logic [7:0] IDX_SP_CTL_CUR  = 8'h0E;
   localparam logic [7:0] IDX_BP_CTL_CUR  = 8'h0F;
   localparam logic [7:0] IDX_SETTLE      = 8'h10;
   localparam logic [7:0] IDX_LANG_HIGH   = 8'h11;
   localparam logic [7:0] IDX_LANG_LOW    = 8'h12;
   localparam logic [7:0] IDX_MAKER_LEN   = 8'h13;
   localparam logic [7:0] IDX_CONTROL     = 8'h20;
   localparam logic [7:0] IDX_STATUS      = 8'h21;
   localparam logic [7:0] IDX_STRING_BASE = 8'h40;
   localparam int         NUM_REGS        = 8;

   // ==========================================================================
   // Reset values.
   localparam logic [7:0] RST_SP_MAX_PWR = 8'h00;
   localparam logic [7:0] RST_BP_MAX_PWR = 8'h32;
   localparam logic [7:0] RST_SP_CTL_CUR = 8'h00;
   localparam logic [7:0] RST_BP_CTL_CUR = 8'h32;
   localparam logic [7:0] RST_OTHER      = 8'h00;

   // ==========================================================================
   // Field positions and limits.
   localparam int         CTL_STRING_EN_BIT = 0;
   localparam int         CTL_LOAD_DONE_BIT = 1;
   localparam int         STS_ENUM_BIT      = 0;
   localparam int         STS_LOCKED_BIT    = 1;
   localparam int         STS_LEN_ERR_BIT   = 2;
   localparam logic [7:0] MAX_STR_CHARS     = 8'h1F;
   localparam int         STR_BYTES         = 62;
   localparam logic [5:0] STR_LAST_BYTE     = 6'h3D;

   // ==========================================================================
   // Carriers.
   typedef struct packed {
      logic [7:0] sp_max_power;
      logic [7:0] bp_max_power;
      logic [7:0] sp_ctl_current;
      logic [7:0] bp_ctl_current;
      logic [7:0] settle_time;
      logic [15:0] language_id;
      logic [7:0] maker_string_length;
      logic       string_enable;
   } desc_cfg_t;

   typedef struct packed {
      logic        req;
      logic [5:0]  addr;
   } str_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] chr;
   } str_rsp_t;

endpackage : hub_cfg_pkg

// >>> hub_cfg_props.sv
// Port assertions for the hub descriptor configuration bank.
// Assumes it is bound to hub_descriptor_config and sees only its ports.
`timescale 1ns/1ps
module hub_cfg_props
(
   // Clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // APB
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Hub core
   input wire logic                   enumerated,
   input wire hub_cfg_pkg::str_req_t  maker_req,
   input wire hub_cfg_pkg::str_rsp_t  maker_rsp,
   input wire hub_cfg_pkg::desc_cfg_t desc_cfg,
   input wire logic                   strings_offered
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // Bus answers.
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_cause: assert property (pslverr |-> psel && penable) else $error("stray error");
   a_err_pulse: assert property (pslverr |=> !pslverr) else $error("error held");
   a_rdata_cause: assert property (prdata != 32'h0 |-> psel && penable && !pwrite)
      else $error("stray read data");
   a_unmapped_err: assert property (psel && penable && paddr == 12'h200 |-> pslverr)
      else $error("unmapped access accepted");
   a_status_ro: assert property (psel && penable && pwrite && paddr == 12'h084 |-> pslverr)
      else $error("status write accepted");
   // =====================================================================
   // Descriptor side.
   a_cfg_frozen: assert property (enumerated && $past(enumerated) |=> $stable(desc_cfg))
      else $error("config moved while enumerated");
   a_chr_answer: assert property (maker_req.req && strings_offered |=> maker_rsp.valid)
      else $error("character not answered");
   a_chr_cause: assert property (maker_rsp.valid |-> $past(maker_req.req))
      else $error("unrequested character");
   a_offer_match: assert property (strings_offered == desc_cfg.string_enable)
      else $error("string offer differs from enable");
   c_err: cover property (pslverr);
   c_chr: cover property (maker_rsp.valid);
   c_frozen: cover property (enumerated && psel && penable && pwrite);
endmodule : hub_cfg_props

// >>> hub_descriptor_config.sv
// APB register bank holding the hub descriptor power, timing and string values.
// Assumes an APB master on pclk; enumerated comes from the hub core on the same clock.
`timescale 1ns/1ps
module hub_descriptor_config
(
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // Hub core
   input  wire logic        enumerated,
   input  wire hub_cfg_pkg::str_req_t maker_req,
   output      hub_cfg_pkg::str_rsp_t maker_rsp,
   output      hub_cfg_pkg::desc_cfg_t desc_cfg,
   output      logic        strings_offered
);

   // =========================================================================
   // Register state.
   logic [7:0] regs_r [hub_cfg_pkg::NUM_REGS];
   logic       string_en_r;
   logic       load_done_r;
   logic       len_err_r;
   logic [31:0] prdata_r;
   logic       pslverr_r;

   // =========================================================================
   // Decode.
   wire        access;
   wire        setup;
   wire        wr_acc;
   wire        rd_acc;
   wire [9:0]  word;
   wire        word_aligned;
   wire        in_cfg;
   wire [2:0]  cfg_idx;
   wire        is_ctl;
   wire        is_sts;
   wire        is_str;
   wire [5:0]  str_addr;
   wire        locked;
   wire        mapped;
   wire        wr_blocked;
   wire [7:0]  str_rd;
   wire [7:0]  cfg_rd;
   wire [7:0]  rd_byte;
   wire        wr_cfg;
   wire        wr_str;
   wire        wr_ctl;

   assign access       = psel && penable;
   assign setup        = psel && !penable;
   assign wr_acc       = access && pwrite;
   // Reads and refusals are decided in the setup phase, so that their answer stands
   // in the one access cycle that a pready tied high allows.
   assign rd_acc       = setup && !pwrite;
   assign word         = paddr[11:2];
   assign word_aligned = (paddr[1:0] == 2'b00) && (word[9:8] == 2'b00);
   assign in_cfg       = word_aligned && (word[7:0] >= hub_cfg_pkg::IDX_SP_MAX_PWR)
                         && (word[7:0] <= hub_cfg_pkg::IDX_MAKER_LEN);
   assign cfg_idx      = 3'(word[7:0] - hub_cfg_pkg::IDX_SP_MAX_PWR);
   assign is_ctl       = word_aligned && (word[7:0] == hub_cfg_pkg::IDX_CONTROL);
   assign is_sts       = word_aligned && (word[7:0] == hub_cfg_pkg::IDX_STATUS);
   assign is_str       = word_aligned && (word[7:0] >= hub_cfg_pkg::IDX_STRING_BASE)
                         && (word[7:0] < 8'(hub_cfg_pkg::IDX_STRING_BASE + 8'h3E));
   assign str_addr     = 6'(word[7:0] - hub_cfg_pkg::IDX_STRING_BASE);
   assign mapped       = in_cfg || is_ctl || is_sts || is_str;
   // Freezing during enumeration stops the host seeing descriptors change mid-session.
   assign locked       = enumerated || load_done_r;
   assign wr_blocked   = setup && pwrite && (is_sts || ((in_cfg || is_str || is_ctl) && locked));
   assign wr_cfg       = wr_acc && in_cfg && !locked && pstrb[0];
   assign wr_str       = wr_acc && is_str && !locked && pstrb[0];
   assign wr_ctl       = wr_acc && is_ctl && !enumerated && pstrb[0];
   assign cfg_rd       = regs_r[cfg_idx];
   assign rd_byte      = in_cfg ? cfg_rd
                       : is_str ? str_rd
                       : is_ctl ? {6'h00, load_done_r, string_en_r}
                       : is_sts ? {5'h00, len_err_r, locked, enumerated}
                       : 8'h00;

   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // =========================================================================
   // Configuration registers, all eight bits wide, the first five in 2 mA or 2 ms units.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         regs_r[0] <= hub_cfg_pkg::RST_SP_MAX_PWR;
         regs_r[1] <= hub_cfg_pkg::RST_BP_MAX_PWR;
         regs_r[2] <= hub_cfg_pkg::RST_SP_CTL_CUR;
         regs_r[3] <= hub_cfg_pkg::RST_BP_CTL_CUR;
         regs_r[4] <= hub_cfg_pkg::RST_OTHER;
         regs_r[5] <= hub_cfg_pkg::RST_OTHER;
         regs_r[6] <= hub_cfg_pkg::RST_OTHER;
         regs_r[7] <= hub_cfg_pkg::RST_OTHER;
      end
      else if (wr_cfg)
      begin
         regs_r[cfg_idx] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         string_en_r <= 1'b0;
         load_done_r <= 1'b0;
      end
      else if (wr_ctl)
      begin
         string_en_r <= load_done_r ? string_en_r : pwdata[hub_cfg_pkg::CTL_STRING_EN_BIT];
         load_done_r <= load_done_r | pwdata[hub_cfg_pkg::CTL_LOAD_DONE_BIT];
      end
   end

   // Software must keep the length legal; an oversize value is flagged, not clipped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         len_err_r <= 1'b0;
      end
      else
      begin
         len_err_r <= regs_r[7] > hub_cfg_pkg::MAX_STR_CHARS;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r  <= (rd_acc && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         pslverr_r <= setup && (!mapped || wr_blocked);
      end
   end

   // =========================================================================
   // Maker string store.
   maker_string_store u_store
   (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_str),
      .wr_addr (str_addr),
      .wr_data (pwdata[7:0]),
      .rd_addr (str_addr),
      .rd_data (str_rd),
      .chr_req (maker_req),
      .chr_rsp (maker_rsp)
   );

   // =========================================================================
   // Descriptor values; the power figures are passed as written, peripheral draw included.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         desc_cfg        <= '0;
         strings_offered <= 1'b0;
      end
      else
      begin
         desc_cfg.sp_max_power        <= regs_r[0];
         desc_cfg.bp_max_power        <= regs_r[1];
         desc_cfg.sp_ctl_current      <= regs_r[2];
         desc_cfg.bp_ctl_current      <= regs_r[3];
         desc_cfg.settle_time         <= regs_r[4];
         desc_cfg.language_id         <= {regs_r[5], regs_r[6]};
         desc_cfg.maker_string_length <= regs_r[7];
         desc_cfg.string_enable       <= string_en_r;
         strings_offered              <= string_en_r;
      end
   end

endmodule : hub_descriptor_config

// >>> maker_string_store.sv
// Maker string byte store and UTF-16LE character assembly.
// Assumes writes and byte reads come from the register bank and character reads from the descriptor engine.
`timescale 1ns/1ps
module maker_string_store
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Byte write port
   input  wire logic                  wr_en,
   input  wire logic [5:0]            wr_addr,
   input  wire logic [7:0]            wr_data,
   // Byte read port for software
   input  wire logic [5:0]            rd_addr,
   output      logic [7:0]            rd_data,
   // Character port for the descriptor engine, addr is a character index
   input  wire hub_cfg_pkg::str_req_t chr_req,
   output      hub_cfg_pkg::str_rsp_t chr_rsp
);

   logic [7:0] mem_r [hub_cfg_pkg::STR_BYTES];
   wire  [5:0] lo_addr;
   wire  [5:0] hi_addr;
   wire        wr_ok;

   assign wr_ok   = wr_en && (wr_addr <= hub_cfg_pkg::STR_LAST_BYTE);
   assign lo_addr = {chr_req.addr[4:0], 1'b0};
   assign hi_addr = {chr_req.addr[4:0], 1'b1};
   assign rd_data = (rd_addr <= hub_cfg_pkg::STR_LAST_BYTE) ? mem_r[rd_addr] : 8'h00;

   always_ff @(posedge pclk)
   begin
      if (wr_ok)
      begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // Low byte sits at the even address, high byte at the next one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chr_rsp <= '0;
      end
      else
      begin
         chr_rsp.valid <= chr_req.req && (chr_req.addr[5] == 1'b0) && (chr_req.addr != 6'h1F);
         chr_rsp.chr   <= {mem_r[hi_addr], mem_r[lo_addr]};
      end
   end

endmodule : maker_string_store

// >>> tb_top.sv
// Self-checking bench for the hub descriptor configuration bank.
// Assumes hub_cfg_pkg, host_reader and hub_cfg_props are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
   logic                   pclk, presetn, psel, penable, pwrite, enumerated;
   logic                   pready, pslverr, strings_offered, err, ok;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic [3:0]             pstrb;
   logic [15:0]            chr;
   hub_cfg_pkg::str_req_t  maker_req;
   hub_cfg_pkg::str_rsp_t  maker_rsp;
   hub_cfg_pkg::desc_cfg_t desc_cfg;
   int                     n_errors = 0;
   int                     checks = 0;
   hub_descriptor_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .enumerated(enumerated),
      .maker_req(maker_req), .maker_rsp(maker_rsp), .desc_cfg(desc_cfg),
      .strings_offered(strings_offered));
   host_reader host_u (.pclk(pclk), .strings_offered(strings_offered),
      .maker_rsp(maker_rsp), .maker_req(maker_req));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task finish_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // =====================================================================
   // Read data and the error flag are taken at the edge at which pready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
         begin
            rd = prdata;
            err = pslverr;
            break;
         end
      end
      if (i == 20) begin n_errors++; finish_test(); end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task t_reset;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 12'h030 + 12'(4 * i), 32'h0);
         `CHK(rd, (i == 1 || i == 3) ? 32'h32 : 32'h0)
      end
      `CHK(desc_cfg.bp_ctl_current, 8'h32)
   endtask : t_reset
   // Upper write bits are set on purpose; each register keeps one byte.
   task t_regs;
      logic [7:0] v [8] = '{8'h32, 8'hC8, 8'h19, 8'h7D, 8'h64, 8'h04, 8'h09, 8'h1F};
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 12'h030 + 12'(4 * i), {24'hFFFFFF, v[i]});
         apb(1'b0, 12'h030 + 12'(4 * i), 32'h0);
         `CHK(rd, {24'h0, v[i]})
      end
      `CHK(desc_cfg.sp_max_power, v[0])
      `CHK(desc_cfg.bp_max_power, v[1])
      `CHK(desc_cfg.sp_ctl_current, v[2])
      `CHK(desc_cfg.bp_ctl_current, v[3])
      `CHK(desc_cfg.settle_time, v[4])
      `CHK(desc_cfg.maker_string_length, v[7])
      `CHK(desc_cfg.language_id, {v[5], v[6]})
      apb(1'b1, 12'h04C, 32'h20);
      apb(1'b0, 12'h084, 32'h0);
      `CHK(rd, 32'h4)
      apb(1'b1, 12'h04C, 32'h1F);
   endtask : t_regs
   task t_string;
      `CHK(strings_offered, 1'b0)
      apb(1'b1, 12'h100, 32'h41);
      apb(1'b1, 12'h104, 32'h0);
      apb(1'b1, 12'h1F0, 32'h34);
      apb(1'b1, 12'h1F4, 32'h12);
      apb(1'b1, 12'h080, 32'h1);
      @(posedge pclk);
      #1;
      `CHK(strings_offered, 1'b1)
      `CHK(desc_cfg.string_enable, 1'b1)
      host_u.fetch(6'd0, ok, chr);
      `CHK({ok, chr}, 17'h10041)
      host_u.fetch(6'd30, ok, chr);
      `CHK({ok, chr}, 17'h11234)
   endtask : t_string
   task t_lock;
      apb(1'b1, 12'h080, 32'h3);
      `CHK(err, 1'b0)
      enumerated <= 1'b1;
      apb(1'b1, 12'h030, 32'h1);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h030, 32'h0);
      `CHK(rd, 32'h32)
      `CHK(desc_cfg.sp_max_power, 8'h32)
      apb(1'b0, 12'h084, 32'h0);
      `CHK(rd, 32'h3)
      apb(1'b1, 12'h084, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h200, 32'h0);
      `CHK(err, 1'b1)
   endtask : t_lock
   // A second reset must clear the lock and bring back the default values.
   task t_rereset;
      enumerated <= 1'b0;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h084, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h030, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(desc_cfg.bp_max_power, 8'h32)
      `CHK(strings_offered, 1'b0)
   endtask : t_rereset
   initial
   begin
      {presetn, psel, penable, pwrite, enumerated, paddr, pwdata, pstrb} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_string();
      t_lock();
      t_rereset();
      finish_test();
   end
endmodule : tb_top
bind hub_descriptor_config hub_cfg_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .enumerated(enumerated),
   .maker_req(maker_req), .maker_rsp(maker_rsp), .desc_cfg(desc_cfg),
   .strings_offered(strings_offered));
